// ---- rtl/afsc_host.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "afsc_map.svh"
module afsc_host
(
    input wire logic sys_clk_i,
    input wire logic srst_i,
    afsc_if.host bus,
    input wire logic [3:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [3:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i
);
    import afsc_pkg::*;

    // reserved offsets and, with the shutdown pin high, writes other than volume and power
    function automatic logic refuse(input afsc_byte_t a, input logic w, input logic run);
        logic rsvd;
        logic vol;
        rsvd = (a == `AFSC_ADDR_RSVD_A)
            || (a >= `AFSC_ADDR_RSVD_LO && a <= `AFSC_ADDR_RSVD_HI);
        vol = (a == `AFSC_ADDR_VOL_L) || (a == `AFSC_ADDR_VOL_R) || (a == `AFSC_ADDR_POWER);
        refuse = rsvd || (w && run && !vol);
    endfunction

    function automatic afsc_byte_t mask_wr(input afsc_byte_t a, input afsc_byte_t d);
        if (a == `AFSC_ADDR_FAULT)
            mask_wr = d & `AFSC_FLT_RSV_MASK;
        else if (a == `AFSC_ADDR_CLIP_LOW)
            mask_wr = d & `AFSC_CLIP_RSV_MASK;
        else
            mask_wr = d;
    endfunction

    afsc_host_state_t state_reg, state_next;
    logic aw_full_reg, aw_full_next;
    logic [3:0] aw_addr_reg, aw_addr_next;
    logic w_full_reg, w_full_next;
    logic [31:0] w_data_reg, w_data_next;
    logic [3:0] w_strb_reg, w_strb_next;
    logic bvalid_reg, bvalid_next;
    logic [1:0] bresp_reg, bresp_next;
    logic rvalid_reg, rvalid_next;
    logic [1:0] rresp_reg, rresp_next;
    logic [31:0] rdata_reg, rdata_next;
    logic req_reg, req_next;
    logic we_reg, we_next;
    afsc_byte_t addr_reg, addr_next;
    afsc_byte_t wdata_reg, wdata_next;
    afsc_byte_t last_reg, last_next;
    logic refused_reg, refused_next;
    logic done_reg, done_next;
    logic sd_n_reg, sd_n_next;

    logic commit;
    logic set_refused;
    logic set_done;
    afsc_byte_t cmd_addr;

    assign commit = aw_full_reg && w_full_reg && !bvalid_reg;
    assign cmd_addr = w_data_reg[7:0];

    always_comb
    begin
        state_next = state_reg;
        aw_full_next = aw_full_reg;
        aw_addr_next = aw_addr_reg;
        w_full_next = w_full_reg;
        w_data_next = w_data_reg;
        w_strb_next = w_strb_reg;
        bvalid_next = bvalid_reg && !s_axi_bready_i;
        bresp_next = bresp_reg;
        rvalid_next = rvalid_reg && !s_axi_rready_i;
        rresp_next = rresp_reg;
        rdata_next = rdata_reg;
        req_next = req_reg;
        we_next = we_reg;
        addr_next = addr_reg;
        wdata_next = wdata_reg;
        last_next = last_reg;
        sd_n_next = sd_n_reg;
        set_refused = 1'b0;
        set_done = 1'b0;
        refused_next = refused_reg;
        done_next = done_reg;
        if (s_axi_awvalid_i && s_axi_awready_o)
        begin
            aw_full_next = 1'b1;
            aw_addr_next = s_axi_awaddr_i;
        end
        if (s_axi_wvalid_i && s_axi_wready_o)
        begin
            w_full_next = 1'b1;
            w_data_next = s_axi_wdata_i;
            w_strb_next = s_axi_wstrb_i;
        end
        if (commit)
        begin
            aw_full_next = 1'b0;
            w_full_next = 1'b0;
            bvalid_next = 1'b1;
            bresp_next = `AFSC_AXI_OKAY;
            case (aw_addr_reg)
                `AFSC_HOST_CMD:
                begin
                    if (w_strb_reg[2:0] == 3'h7)
                    begin
                        if (state_reg != AFSC_HS_IDLE
                            || refuse(cmd_addr, w_data_reg[`AFSC_CMD_WRITE], sd_n_reg))
                            set_refused = 1'b1;
                        else
                        begin
                            req_next = 1'b1;
                            we_next = w_data_reg[`AFSC_CMD_WRITE];
                            addr_next = cmd_addr;
                            wdata_next = mask_wr(cmd_addr, w_data_reg[15:8]);
                            state_next = AFSC_HS_WAIT;
                        end
                    end
                end
                `AFSC_HOST_STATUS:
                begin
                    if (w_strb_reg[0])
                    begin
                        refused_next = refused_reg && !w_data_reg[`AFSC_ST_REFUSED];
                        done_next = done_reg && !w_data_reg[`AFSC_ST_DONE];
                    end
                end
                `AFSC_HOST_CTRL:
                begin
                    if (w_strb_reg[0])
                        sd_n_next = w_data_reg[0];
                end
                default: bresp_next = `AFSC_AXI_SLVERR;
            endcase
        end
        if (state_reg == AFSC_HS_WAIT && bus.ack)
        begin
            req_next = 1'b0;
            last_next = bus.rdata;
            set_done = 1'b1;
            state_next = AFSC_HS_IDLE;
        end
        // a new event wins over the software clear
        refused_next = refused_next || set_refused;
        done_next = done_next || set_done;
        if (s_axi_arvalid_i && s_axi_arready_o)
        begin
            rvalid_next = 1'b1;
            rresp_next = `AFSC_AXI_OKAY;
            rdata_next = 32'h0000_0000;
            case (s_axi_araddr_i)
                `AFSC_HOST_CMD: rdata_next = {15'h0000, we_reg, wdata_reg, addr_reg};
                `AFSC_HOST_STATUS: rdata_next = {16'h0000, last_reg, 5'h00,
                    done_reg, refused_reg, state_reg == AFSC_HS_WAIT};
                `AFSC_HOST_CTRL: rdata_next = {31'h0000_0000, sd_n_reg};
                default: rresp_next = `AFSC_AXI_SLVERR;
            endcase
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (srst_i)
        begin
            state_reg <= AFSC_HS_IDLE;
            aw_full_reg <= 1'b0;
            aw_addr_reg <= 4'h0;
            w_full_reg <= 1'b0;
            w_data_reg <= 32'h0000_0000;
            w_strb_reg <= 4'h0;
            bvalid_reg <= 1'b0;
            bresp_reg <= `AFSC_AXI_OKAY;
            rvalid_reg <= 1'b0;
            rresp_reg <= `AFSC_AXI_OKAY;
            rdata_reg <= 32'h0000_0000;
            req_reg <= 1'b0;
            we_reg <= 1'b0;
            addr_reg <= 8'h00;
            wdata_reg <= 8'h00;
            last_reg <= 8'h00;
            refused_reg <= 1'b0;
            done_reg <= 1'b0;
            sd_n_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            aw_full_reg <= aw_full_next;
            aw_addr_reg <= aw_addr_next;
            w_full_reg <= w_full_next;
            w_data_reg <= w_data_next;
            w_strb_reg <= w_strb_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
            rvalid_reg <= rvalid_next;
            rresp_reg <= rresp_next;
            rdata_reg <= rdata_next;
            req_reg <= req_next;
            we_reg <= we_next;
            addr_reg <= addr_next;
            wdata_reg <= wdata_next;
            last_reg <= last_next;
            refused_reg <= refused_next;
            done_reg <= done_next;
            sd_n_reg <= sd_n_next;
        end
    end

    assign s_axi_awready_o = !aw_full_reg && !bvalid_reg;
    assign s_axi_wready_o = !w_full_reg && !bvalid_reg;
    assign s_axi_bvalid_o = bvalid_reg;
    assign s_axi_bresp_o = bresp_reg;
    assign s_axi_arready_o = !rvalid_reg;
    assign s_axi_rvalid_o = rvalid_reg;
    assign s_axi_rresp_o = rresp_reg;
    assign s_axi_rdata_o = rdata_reg;
    assign bus.req = req_reg;
    assign bus.we = we_reg;
    assign bus.addr = addr_reg;
    assign bus.wdata = wdata_reg;
    assign bus.amp_shutdown_n = sd_n_reg;
endmodule // afsc_host
`default_nettype wire

// ---- pkg/afsc_map.svh ----
`ifndef AFSC_MAP_SVH
`define AFSC_MAP_SVH
// device register offsets
`define AFSC_ADDR_POWER 8'h03
`define AFSC_ADDR_VOL_L 8'h04
`define AFSC_ADDR_VOL_R 8'h05
`define AFSC_ADDR_RSVD_A 8'h07
`define AFSC_ADDR_FAULT 8'h08
`define AFSC_ADDR_RSVD_LO 8'h09
`define AFSC_ADDR_RSVD_HI 8'h0f
`define AFSC_ADDR_CLIP_MID 8'h10
`define AFSC_ADDR_CLIP_LOW 8'h11
// device reset values
`define AFSC_RST_OCSEL 2'h0
`define AFSC_RST_CLIP_MID 8'h01
`define AFSC_RST_CLIP_LOW 6'h01
`define AFSC_RST_CLIP_RSV 2'h0
`define AFSC_RST_RUN 1'b0
// fault register fields and reserved-bit write masks
`define AFSC_FLT_OT 0
`define AFSC_FLT_DC 1
`define AFSC_FLT_OC 2
`define AFSC_FLT_CLK 3
`define AFSC_FLT_SEL_LSB 4
`define AFSC_FLT_SEL_MSB 5
`define AFSC_FLT_RSV_MASK 8'h3f
`define AFSC_CLIP_RSV_MASK 8'hfc
// over-current scale codes
`define AFSC_OC_FULL 2'h0
`define AFSC_OC_75 2'h1
`define AFSC_OC_50 2'h2
`define AFSC_OC_25 2'h3
// controller register offsets (axi byte addresses)
`define AFSC_HOST_CMD 4'h0
`define AFSC_HOST_STATUS 4'h4
`define AFSC_HOST_CTRL 4'h8
// controller fields
`define AFSC_CMD_WRITE 16
`define AFSC_ST_BUSY 0
`define AFSC_ST_REFUSED 1
`define AFSC_ST_DONE 2
`define AFSC_AXI_OKAY 2'h0
`define AFSC_AXI_SLVERR 2'h2
`endif

// ---- pkg/afsc_pkg.sv ----
`default_nettype none
package afsc_pkg;
    typedef logic [7:0] afsc_byte_t;
    typedef logic [19:0] afsc_clip_t;
    typedef enum logic {AFSC_HS_IDLE, AFSC_HS_WAIT} afsc_host_state_t;
endpackage
`default_nettype wire

// ---- pkg/afsc_if.sv ----
`timescale 1ns/1ns
`default_nettype none
interface afsc_if;
    logic req;
    logic we;
    afsc_pkg::afsc_byte_t addr;
    afsc_pkg::afsc_byte_t wdata;
    afsc_pkg::afsc_byte_t rdata;
    logic ack;
    logic amp_shutdown_n;
    modport dev
    (
        input req, we, addr, wdata, amp_shutdown_n,
        output rdata, ack
    );
    modport host
    (
        output req, we, addr, wdata, amp_shutdown_n,
        input rdata, ack
    );
endinterface // afsc_if
`default_nettype wire

// ---- rtl/afsc_device.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "afsc_map.svh"
// Operation
// - host never touches reserved offset 0x07
// - host never touches offsets 0x09 to 0x0F
// - fault bits 7:6 read zero, kept
// - bits 5:4 scale over-current trip level
// - clock fault flag follows error, self-clears
// - over-current flag latches until shutdown toggle
// - dc-offset flag latches until shutdown toggle
// - over-temperature flag latches until shutdown toggle
// - host toggles shutdown to clear latched faults
// - clip threshold assembled from three fields
// - offset 0x10 holds threshold bits 13:6
// - offset 0x11 bits 7:2 hold bits 5:0
// - host writes zero to 0x11 bits 1:0
// - shutdown by low pin or cleared bit
// - host changes non-volume registers while the shutdown pin is low
module afsc_device
#(
    parameter int CUR_W = 10,
    parameter logic [9:0] OC_NOMINAL = 10'h3e8,
    parameter int SAMPLE_W = 24
)
(
    input wire logic sys_clk_i,
    input wire logic srst_i,
    afsc_if.dev bus,
    input wire logic clock_err_i,
    input wire logic [CUR_W-1:0] current_mag_i,
    input wire logic dc_offset_err_i,
    input wire logic overtemp_i,
    input wire logic [5:0] clip_level_hi_i,
    input wire logic sample_valid_i,
    input wire logic signed [SAMPLE_W-1:0] sample_i,
    output logic sample_valid_o,
    output logic signed [SAMPLE_W-1:0] sample_o,
    output logic amp_active_o,
    output logic [CUR_W-1:0] oc_trip_level_o,
    output afsc_pkg::afsc_clip_t clip_threshold_level_o
);
    import afsc_pkg::*;

    typedef logic signed [SAMPLE_W:0] afsc_wide_t;

    function automatic logic [CUR_W-1:0] oc_scale(input logic [1:0] sel);
        logic [CUR_W-1:0] nom;
        nom = OC_NOMINAL[CUR_W-1:0];
        case (sel)
            `AFSC_OC_FULL: oc_scale = nom;
            `AFSC_OC_75: oc_scale = nom - (nom >> 2);
            `AFSC_OC_50: oc_scale = nom >> 1;
            `AFSC_OC_25: oc_scale = nom >> 2;
            default: oc_scale = nom;
        endcase
    endfunction

    function automatic logic signed [SAMPLE_W-1:0] clip_sample
    (
        input logic signed [SAMPLE_W-1:0] s,
        input afsc_clip_t thr
    );
        afsc_wide_t pos;
        afsc_wide_t neg;
        afsc_wide_t sw;
        pos = afsc_wide_t'({1'b0, thr});
        neg = -pos;
        sw = afsc_wide_t'(s);
        if (sw > pos)
            clip_sample = pos[SAMPLE_W-1:0];
        else if (sw < neg)
            clip_sample = neg[SAMPLE_W-1:0];
        else
            clip_sample = s;
    endfunction

    // configuration and fault state
    logic [1:0] ocsel_reg, ocsel_next;
    afsc_byte_t clip_mid_reg, clip_mid_next;
    logic [5:0] clip_low_reg, clip_low_next;
    logic [1:0] clip_rsv_reg, clip_rsv_next;
    logic run_reg, run_next;
    logic clk_flt_reg, clk_flt_next;
    logic oc_flt_reg, oc_flt_next;
    logic dc_flt_reg, dc_flt_next;
    logic ot_flt_reg, ot_flt_next;
    logic pin_reg, pin_next;
    // register port answer
    logic ack_reg, ack_next;
    afsc_byte_t rdata_reg, rdata_next;
    // output stage
    logic svalid_reg, svalid_next;
    logic signed [SAMPLE_W-1:0] sample_reg, sample_next;
    logic [CUR_W-1:0] trip_reg, trip_next;

    logic take;
    logic toggled;
    logic active;
    afsc_clip_t clip_thr;
    afsc_byte_t fault_view;

    assign take = bus.req && !ack_reg;
    assign toggled = pin_reg != bus.amp_shutdown_n;
    assign clip_thr = {clip_level_hi_i, clip_mid_reg, clip_low_reg};
    assign fault_view = {2'b00, ocsel_reg, clk_flt_reg, oc_flt_reg,
        dc_flt_reg, ot_flt_reg};
    assign active = bus.amp_shutdown_n && run_reg && !clk_flt_reg
        && !oc_flt_reg && !dc_flt_reg && !ot_flt_reg;

    always_comb
    begin
        ocsel_next = ocsel_reg;
        clip_mid_next = clip_mid_reg;
        clip_low_next = clip_low_reg;
        clip_rsv_next = clip_rsv_reg;
        run_next = run_reg;
        rdata_next = rdata_reg;
        ack_next = take;
        pin_next = bus.amp_shutdown_n;
        if (take && bus.we)
        begin
            case (bus.addr)
                `AFSC_ADDR_FAULT:
                    ocsel_next = bus.wdata[`AFSC_FLT_SEL_MSB:`AFSC_FLT_SEL_LSB];
                `AFSC_ADDR_CLIP_MID: clip_mid_next = bus.wdata;
                `AFSC_ADDR_CLIP_LOW:
                begin
                    clip_low_next = bus.wdata[7:2];
                    clip_rsv_next = bus.wdata[1:0];
                end
                `AFSC_ADDR_POWER: run_next = bus.wdata[0];
                default: ;
            endcase
        end
        if (take)
        begin
            case (bus.addr)
                `AFSC_ADDR_FAULT: rdata_next = fault_view;
                `AFSC_ADDR_CLIP_MID: rdata_next = clip_mid_reg;
                `AFSC_ADDR_CLIP_LOW: rdata_next = {clip_low_reg, clip_rsv_reg};
                `AFSC_ADDR_POWER: rdata_next = {7'h00, run_reg};
                default: rdata_next = 8'h00;
            endcase
        end
        // clock fault is a live copy, no latch
        clk_flt_next = clock_err_i;
        // latched faults: a new event wins over a toggle clear
        oc_flt_next = (current_mag_i > trip_reg)
            || (oc_flt_reg && !toggled);
        dc_flt_next = dc_offset_err_i || (dc_flt_reg && !toggled);
        ot_flt_next = overtemp_i || (ot_flt_reg && !toggled);
        trip_next = oc_scale(ocsel_reg);
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (srst_i)
        begin
            ocsel_reg <= `AFSC_RST_OCSEL;
            clip_mid_reg <= `AFSC_RST_CLIP_MID;
            clip_low_reg <= `AFSC_RST_CLIP_LOW;
            clip_rsv_reg <= `AFSC_RST_CLIP_RSV;
            run_reg <= `AFSC_RST_RUN;
            rdata_reg <= 8'h00;
            ack_reg <= 1'b0;
            pin_reg <= 1'b0;
            clk_flt_reg <= 1'b0;
            oc_flt_reg <= 1'b0;
            dc_flt_reg <= 1'b0;
            ot_flt_reg <= 1'b0;
            trip_reg <= OC_NOMINAL[CUR_W-1:0];
        end
        else
        begin
            ocsel_reg <= ocsel_next;
            clip_mid_reg <= clip_mid_next;
            clip_low_reg <= clip_low_next;
            clip_rsv_reg <= clip_rsv_next;
            run_reg <= run_next;
            rdata_reg <= rdata_next;
            ack_reg <= ack_next;
            pin_reg <= pin_next;
            clk_flt_reg <= clk_flt_next;
            oc_flt_reg <= oc_flt_next;
            dc_flt_reg <= dc_flt_next;
            ot_flt_reg <= ot_flt_next;
            trip_reg <= trip_next;
        end
    end

    // output stage: silent while shut down or faulted
    always_comb
    begin
        svalid_next = sample_valid_i;
        sample_next = sample_reg;
        if (sample_valid_i)
        begin
            if (active)
                sample_next = clip_sample(sample_i, clip_thr);
            else
                sample_next = '0;
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (srst_i)
        begin
            svalid_reg <= 1'b0;
            sample_reg <= '0;
        end
        else
        begin
            svalid_reg <= svalid_next;
            sample_reg <= sample_next;
        end
    end

    assign bus.ack = ack_reg;
    assign bus.rdata = rdata_reg;
    assign sample_valid_o = svalid_reg;
    assign sample_o = sample_reg;
    assign amp_active_o = active;
    assign oc_trip_level_o = trip_reg;
    assign clip_threshold_level_o = clip_thr;
endmodule // afsc_device
`default_nettype wire

// ---- tb/afsc_monitor.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "afsc_map.svh"
module afsc_monitor
(
    input wire logic sys_clk_i,
    input wire logic srst_i,
    input wire logic req,
    input wire logic we,
    input wire afsc_pkg::afsc_byte_t addr,
    input wire afsc_pkg::afsc_byte_t wdata,
    input wire afsc_pkg::afsc_byte_t rdata,
    input wire logic ack,
    input wire logic amp_shutdown_n
);
    import afsc_pkg::*;
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (srst_i);
    logic taken;
    afsc_byte_t mid_reg;
    afsc_byte_t mid_next;
    assign taken = req && !ack;
    // shadow of the mid clip byte, updated on taken writes
    always_comb
    begin
        mid_next = mid_reg;
        if (taken && we && addr == `AFSC_ADDR_CLIP_MID)
        begin
            mid_next = wdata;
        end
    end
    always_ff @(posedge sys_clk_i)
    begin
        mid_reg <= srst_i ? `AFSC_RST_CLIP_MID : mid_next;
    end
    sequence s_read(afsc_byte_t a);
        taken && !we && addr == a ##1 ack;
    endsequence
    sequence s_write(afsc_byte_t a);
        taken && we && addr == a;
    endsequence
    a_ack_next: assert property (taken |=> ack && req)
        else $error("request not answered next cycle");
    a_ack_pulse: assert property (ack |=> !ack)
        else $error("ack longer than one cycle");
    a_ack_cause: assert property (!req |=> !ack)
        else $error("ack without request");
    a_rsvd_skip: assert property (req |-> !(addr inside {8'h07, [8'h09:8'h0f]}))
        else $error("reserved offset requested");
    a_fault_rsv_rd: assert property (s_read(`AFSC_ADDR_FAULT) |-> rdata[7:6] == 2'h0)
        else $error("fault reserved bits not zero");
    a_fault_rsv_wr: assert property (s_write(`AFSC_ADDR_FAULT) |-> wdata[7:6] == 2'h0)
        else $error("fault reserved bits written");
    a_clip_rsv_wr: assert property (s_write(`AFSC_ADDR_CLIP_LOW) |-> wdata[1:0] == 2'h0)
        else $error("clip low reserved bits written");
    a_mid_readback: assert property (s_read(`AFSC_ADDR_CLIP_MID) |-> rdata == mid_reg)
        else $error("clip mid readback wrong");
    a_run_writes: assert property (taken && we && amp_shutdown_n |-> addr inside {[8'h03:8'h05]})
        else $error("write while running");
endmodule // afsc_monitor
`default_nettype wire

// ---- tb/tb_amp_fault_status_clip_regs.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "afsc_map.svh"
module tb_amp_fault_status_clip_regs;
    import afsc_pkg::*;
    localparam logic [9:0] NOM = 10'h3e8;
    localparam logic [9:0] TRIPS [4] = '{NOM, NOM - (NOM >> 2), NOM >> 1, NOM >> 2};
    localparam afsc_byte_t RSVD [3] = '{8'h07, 8'h09, 8'h0f};
    logic sys_clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, sv_i = 1'b0;
    logic clock_err = 1'b0, dc_err = 1'b0, ot_err = 1'b0;
    logic awready, wready, arready, bvalid, rvalid, sv_o, active, rf;
    logic [3:0] awaddr = 4'h0, araddr = 4'h0;
    logic [31:0] wdata = 32'h0, rdata, st;
    logic [1:0] bresp, rresp, resp;
    logic [9:0] cur = 10'h0, trip;
    logic [5:0] hi = 6'h2b;
    logic [23:0] smp = 24'h0, smp_o;
    afsc_byte_t rb;
    afsc_clip_t thr;
    int miscompares = 0, n_checks = 0, cycles = 0;
    afsc_if bus_if();
    afsc_host u_afsc_host (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .bus(bus_if.host),
        .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
        .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid),
        .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
        .s_axi_bready_i(1'b1), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
        .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
        .s_axi_rvalid_o(rvalid), .s_axi_rready_i(1'b1));
    afsc_device #(.OC_NOMINAL(NOM)) u_afsc_device (.sys_clk_i(sys_clk_i), .srst_i(srst_i),
        .bus(bus_if.dev), .clock_err_i(clock_err), .current_mag_i(cur),
        .dc_offset_err_i(dc_err), .overtemp_i(ot_err), .clip_level_hi_i(hi),
        .sample_valid_i(sv_i), .sample_i(smp), .sample_valid_o(sv_o), .sample_o(smp_o),
        .amp_active_o(active), .oc_trip_level_o(trip), .clip_threshold_level_o(thr));
    afsc_monitor u_afsc_monitor (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .req(bus_if.req),
        .we(bus_if.we), .addr(bus_if.addr), .wdata(bus_if.wdata), .rdata(bus_if.rdata),
        .ack(bus_if.ack), .amp_shutdown_n(bus_if.amp_shutdown_n));
    always #25 sys_clk_i = ~sys_clk_i;
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    always @(posedge sys_clk_i)
    begin
        cycles <= cycles + 1;
        if (cycles == 6000)
        begin
            miscompares++;
            summarize();
        end
    end
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // handshakes are judged at the negedge before the edge that takes them
    task automatic axw(input logic [3:0] a, input logic [31:0] d);
        logic ha, hw, hb;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        hb = 1'b0;
        while (!hb)
        begin
            @(negedge sys_clk_i);
            ha = awvalid && awready;
            hw = wvalid && wready;
            hb = bvalid;
            resp = bresp;
            @(posedge sys_clk_i);
            if (ha) awvalid <= 1'b0;
            if (hw) wvalid <= 1'b0;
        end
    endtask
    task automatic axr(input logic [3:0] a, output logic [31:0] d);
        logic ha, hr;
        araddr <= a;
        arvalid <= 1'b1;
        hr = 1'b0;
        while (!hr)
        begin
            @(negedge sys_clk_i);
            ha = arvalid && arready;
            hr = rvalid;
            d = rdata;
            resp = rresp;
            @(posedge sys_clk_i);
            if (ha) arvalid <= 1'b0;
        end
    endtask
    task automatic dev(input logic w, input afsc_byte_t a, input afsc_byte_t d);
        logic [31:0] s;
        axw(`AFSC_HOST_CMD, {15'h0, w, d, a});
        s = 32'h0;
        while (!s[`AFSC_ST_DONE] && !s[`AFSC_ST_REFUSED])
            axr(`AFSC_HOST_STATUS, s);
        rb = s[15:8];
        rf = s[`AFSC_ST_REFUSED];
        axw(`AFSC_HOST_STATUS, 32'h6);
    endtask
    task automatic pin(input logic v);
        axw(`AFSC_HOST_CTRL, {31'h0, v});
        repeat (2) @(posedge sys_clk_i);
    endtask
    task automatic smp_chk(input logic [23:0] s, input logic [23:0] e);
        @(posedge sys_clk_i);
        sv_i <= 1'b1;
        smp <= s;
        @(posedge sys_clk_i);
        sv_i <= 1'b0;
        @(negedge sys_clk_i);
        check("sample_valid", sv_o, 1'b1);
        check("sample", smp_o, e);
    endtask
    initial
    begin
        repeat (6) @(posedge sys_clk_i);
        srst_i <= 1'b0;
        @(posedge sys_clk_i);
        dev(0, `AFSC_ADDR_FAULT, 8'h0);
        check("fault rst", rb, 8'h00);
        dev(0, `AFSC_ADDR_CLIP_MID, 8'h0);
        check("mid rst", rb, 8'h01);
        dev(0, `AFSC_ADDR_CLIP_LOW, 8'h0);
        check("low rst", rb, 8'h04);
        check("thr rst", thr, {hi, 8'h01, 6'h01});
        for (int i = 0; i < 4; i++)
        begin
            dev(1, `AFSC_ADDR_FAULT, {2'h3, 2'(i), 4'hf});
            dev(0, `AFSC_ADDR_FAULT, 8'h0);
            check("fault cfg", rb, {2'h0, 2'(i), 4'h0});
            check("trip", trip, TRIPS[i]);
        end
        // back to the full trip level so later flag reads see zero in bits 5:4
        dev(1, `AFSC_ADDR_FAULT, 8'h00);
        check("trip full", trip, NOM);
        dev(1, `AFSC_ADDR_CLIP_MID, 8'ha5);
        dev(1, `AFSC_ADDR_CLIP_LOW, 8'h5f);
        dev(0, `AFSC_ADDR_CLIP_MID, 8'h0);
        check("mid", rb, 8'ha5);
        dev(0, `AFSC_ADDR_CLIP_LOW, 8'h0);
        check("low", rb, 8'h5c);
        check("thr", thr, {hi, 8'ha5, 6'h17});
        foreach (RSVD[i])
        begin
            dev(0, RSVD[i], 8'h0);
            check("reserved refused", rf, 1'b1);
        end
        axr(4'hc, st);
        check("rresp", resp, `AFSC_AXI_SLVERR);
        axw(4'hc, 32'h0);
        check("bresp", resp, `AFSC_AXI_SLVERR);
        dev(1, `AFSC_ADDR_POWER, 8'h01);
        check("active pin low", active, 1'b0);
        pin(1'b1);
        check("active", active, 1'b1);
        dev(1, `AFSC_ADDR_POWER, 8'h00);
        @(negedge sys_clk_i);
        check("active bit off", active, 1'b0);
        @(posedge sys_clk_i);
        dev(1, `AFSC_ADDR_POWER, 8'h01);
        dev(1, `AFSC_ADDR_CLIP_MID, 8'h3c);
        check("running write refused", rf, 1'b1);
        clock_err <= 1'b1;
        dev(0, `AFSC_ADDR_FAULT, 8'h0);
        check("clock flag", rb, 8'h08);
        check("active clk err", active, 1'b0);
        clock_err <= 1'b0;
        dev(0, `AFSC_ADDR_FAULT, 8'h0);
        check("clock flag clear", rb, 8'h00);
        check("active resumed", active, 1'b1);
        for (int i = 0; i < 3; i++)
        begin
            ot_err <= (i == 0);
            dc_err <= (i == 1);
            cur <= (i == 2) ? 10'h3ff : 10'h0;
            repeat (2) @(posedge sys_clk_i);
            ot_err <= 1'b0;
            dc_err <= 1'b0;
            cur <= 10'h0;
            repeat (20) @(posedge sys_clk_i);
            dev(0, `AFSC_ADDR_FAULT, 8'h0);
            check("fault latched", rb, 8'h01 << i);
            check("active fault", active, 1'b0);
            pin(1'b0);
            pin(1'b1);
            dev(0, `AFSC_ADDR_FAULT, 8'h0);
            check("fault cleared", rb, 8'h00);
            check("active again", active, 1'b1);
        end
        smp_chk(24'h7fffff, {4'h0, thr});
        smp_chk(24'h800001, 24'h0 - {4'h0, thr});
        smp_chk(24'h000123, 24'h000123);
        pin(1'b0);
        smp_chk(24'h000123, 24'h0);
        summarize();
    end
endmodule // tb_amp_fault_status_clip_regs
`default_nettype wire
